// ---- core/spm_pin_mux.sv ----
// shared pin function select: port bits 0..15 versus dma lines and serial
// control, plus the pcm highway marker, clock and transmit data pin handling
// assumes the select bits and user-side signals come from logic on clk_i
// Function
// - select bit zero after reset: dma pins are bidirectional port bits 0..7
// - select bit one: four dma request inputs and four acknowledge outputs
// - serial pins are port bits 8..15 after reset; select bit switches them
// - serial mode: shift clock, two data lines, chip selects 0..3, reserved pin
// - receive marker flags the first bit of the receive frame
// - transmit marker flags the last bit of the transmit frame
// - transmit data drives during active bits, high impedance otherwise
// - drive flag output shows when transmit data is high impedance
// - receive clock clocks data at one of seven selectable line rates
// - transmit clock uses the same selectable line rates
`timescale 1ns/1ns
`default_nettype none
module spm_pin_mux
	import spm_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// function select bits of the global configuration
	input wire logic local_bus_dma_select_i,
	input wire logic serial_control_select_i,
	input wire logic [2:0] line_mode_config_i,
	// general purpose port, user side
	input wire logic [15:0] gpp_out_i,
	input wire logic [15:0] gpp_oe_i,
	output logic [15:0] gpp_in_o,
	// dma, user side
	input wire spm_dma_t dma_ack_i,
	output var spm_dma_t dma_req_o,
	// serial control, user side
	input wire spm_sc_out_t sc_drive_i,
	output var spm_sc_in_t sc_in_o,
	// local-bus dma pins
	input wire logic [7:0] lb_pin_i,
	output logic [7:0] lb_pin_o,
	output logic [7:0] lb_pin_oe_o,
	// serial control pins
	input wire logic [7:0] sc_pin_i,
	output logic [7:0] sc_pin_o,
	output logic [7:0] sc_pin_oe_o,
	// pcm highway pins
	input wire logic line_rx_clock_i,
	input wire logic line_rx_frame_marker_i,
	input wire logic line_rx_data_i,
	input wire logic line_tx_clock_i,
	input wire logic line_tx_frame_marker_i,
	output logic line_tx_data_o,
	output logic line_tx_data_oe_o,
	output logic line_tx_drive_flag_o,
	// pcm highway, core side
	input wire logic tx_bit_i,
	input wire logic tx_bit_active_i,
	output var spm_line_ev_t line_ev_o,
	output logic rate_bad_o
);
	logic [7:0] lb_sync;
	logic [7:0] sc_sync;
	logic [SPM_LINE_W-1:0] ln_sync;
	logic [SPM_LINE_W-1:0] ln_rise;
	logic [SPM_LINE_W-1:0] ln_async;

	logic [15:0] gpp_in_ff;
	spm_dma_t dma_req_ff;
	spm_sc_in_t sc_in_ff;
	logic [7:0] lb_pin_ff;
	logic [7:0] lb_oe_ff;
	logic [7:0] sc_pin_ff;
	logic [7:0] sc_oe_ff;
	logic [7:0] nxt_lb_pin;
	logic [7:0] nxt_lb_oe;
	logic [7:0] nxt_sc_pin;
	logic [7:0] nxt_sc_oe;
	spm_line_ev_t line_ev_ff;
	logic tx_data_ff;
	logic tx_oe_ff;
	logic tx_flag_ff;
	logic rate_bad_ff;
	logic rate_ok;

	// legal line rate codes; shared by both directions
	function automatic logic rate_legal(input logic [2:0] code);
		unique case (code)
			SPM_RATE_1544, SPM_RATE_1536, SPM_RATE_2048, SPM_RATE_4096,
			SPM_RATE_3088, SPM_RATE_6176, SPM_RATE_8192: rate_legal = 1'h1;
			default: rate_legal = 1'h0;
		endcase
	endfunction : rate_legal

	assign ln_async = {line_tx_frame_marker_i, line_tx_clock_i, line_rx_data_i,
		line_rx_frame_marker_i, line_rx_clock_i};

	spm_sync_edge #(.WIDTH(SPM_GRP_W)) u_lb_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(lb_pin_i),
		.level_o(lb_sync),
		.rise_o()
	);

	spm_sync_edge #(.WIDTH(SPM_GRP_W)) u_sc_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(sc_pin_i),
		.level_o(sc_sync),
		.rise_o()
	);

	spm_sync_edge #(.WIDTH(SPM_LINE_W)) u_ln_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(ln_async),
		.level_o(ln_sync),
		.rise_o(ln_rise)
	);

	// local-bus dma group
	always_comb begin
		nxt_lb_pin = gpp_out_i[7:0];
		nxt_lb_oe = gpp_oe_i[7:0];
		if (local_bus_dma_select_i) begin
			nxt_lb_pin = SPM_GRP_RST;
			nxt_lb_oe = SPM_GRP_RST;
			// requests are inputs, acknowledges always driven
			nxt_lb_pin[SPM_LB_ACK_TX_A] = dma_ack_i.tx_a;
			nxt_lb_pin[SPM_LB_ACK_TX_B] = dma_ack_i.tx_b;
			nxt_lb_pin[SPM_LB_ACK_RX_A] = dma_ack_i.rx_a;
			nxt_lb_pin[SPM_LB_ACK_RX_B] = dma_ack_i.rx_b;
			nxt_lb_oe[SPM_LB_ACK_TX_A] = 1'h1;
			nxt_lb_oe[SPM_LB_ACK_TX_B] = 1'h1;
			nxt_lb_oe[SPM_LB_ACK_RX_A] = 1'h1;
			nxt_lb_oe[SPM_LB_ACK_RX_B] = 1'h1;
		end
	end

	// serial control group
	always_comb begin
		nxt_sc_pin = gpp_out_i[15:8];
		nxt_sc_oe = gpp_oe_i[15:8];
		if (serial_control_select_i) begin
			nxt_sc_pin = SPM_GRP_RST;
			nxt_sc_oe = SPM_GRP_RST;
			nxt_sc_pin[SPM_SC_SHIFT_CLK] = sc_drive_i.shift_clk;
			nxt_sc_oe[SPM_SC_SHIFT_CLK] = sc_drive_i.shift_clk_oe;
			nxt_sc_pin[SPM_SC_OUT_MASTER] = sc_drive_i.serial_out_master;
			nxt_sc_oe[SPM_SC_OUT_MASTER] = sc_drive_i.serial_out_master_oe;
			nxt_sc_pin[SPM_SC_IN_MASTER] = sc_drive_i.serial_in_master;
			nxt_sc_oe[SPM_SC_IN_MASTER] = sc_drive_i.serial_in_master_oe;
			// reserved pin stays undriven; chip selects run downward, cs0 at 3, cs3 at 0
			for (int k = 0; k < 4; k++) begin
				nxt_sc_pin[SPM_SC_CS0-k] = sc_drive_i.serial_chip_select[k];
			end
			nxt_sc_oe[SPM_SC_CS0-:4] = 4'hF;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lb_pin_ff <= SPM_GRP_RST;
			lb_oe_ff <= SPM_GRP_RST;
			sc_pin_ff <= SPM_GRP_RST;
			sc_oe_ff <= SPM_GRP_RST;
		end else begin
			lb_pin_ff <= nxt_lb_pin;
			lb_oe_ff <= nxt_lb_oe;
			sc_pin_ff <= nxt_sc_pin;
			sc_oe_ff <= nxt_sc_oe;
		end
	end

	// pins are always read back so software sees the wire in either function
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gpp_in_ff <= 16'h0000;
			dma_req_ff <= '0;
			sc_in_ff <= '0;
		end else begin
			gpp_in_ff <= {sc_sync, lb_sync};
			// requests are level-held by the peripheral until acknowledged
			if (local_bus_dma_select_i) begin
				dma_req_ff.tx_a <= lb_sync[SPM_LB_REQ_TX_A];
				dma_req_ff.rx_a <= lb_sync[SPM_LB_REQ_RX_A];
				dma_req_ff.tx_b <= lb_sync[SPM_LB_REQ_TX_B];
				dma_req_ff.rx_b <= lb_sync[SPM_LB_REQ_RX_B];
			end else begin
				dma_req_ff <= '0;
			end
			if (serial_control_select_i) begin
				sc_in_ff.shift_clk <= sc_sync[SPM_SC_SHIFT_CLK];
				sc_in_ff.serial_out_master <= sc_sync[SPM_SC_OUT_MASTER];
				sc_in_ff.serial_in_master <= sc_sync[SPM_SC_IN_MASTER];
			end else begin
				sc_in_ff <= '0;
			end
		end
	end

	// an unknown rate code stops both directions rather than clock garbage
	assign rate_ok = rate_legal(line_mode_config_i);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			line_ev_ff <= '0;
			rate_bad_ff <= 1'h0;
		end else begin
			rate_bad_ff <= ~rate_ok;
			line_ev_ff.rx_bit <= rate_ok & ln_rise[SPM_LN_RX_CLK];
			line_ev_ff.rx_frame_first <= rate_ok & ln_rise[SPM_LN_RX_CLK]
				& ln_sync[SPM_LN_RX_MARK];
			line_ev_ff.tx_bit <= rate_ok & ln_rise[SPM_LN_TX_CLK];
			line_ev_ff.tx_frame_last <= rate_ok & ln_rise[SPM_LN_TX_CLK]
				& ln_sync[SPM_LN_TX_MARK];
			if (rate_ok && ln_rise[SPM_LN_RX_CLK]) begin
				line_ev_ff.rx_data <= ln_sync[SPM_LN_RX_DATA];
			end
		end
	end

	// transmit pin changes on a transmit clock edge, or is released at once when the rate code turns illegal
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_data_ff <= 1'h0;
			tx_oe_ff <= 1'h0;
			tx_flag_ff <= 1'h1;
		end else if (rate_ok && ln_rise[SPM_LN_TX_CLK]) begin
			tx_data_ff <= tx_bit_active_i & tx_bit_i;
			tx_oe_ff <= tx_bit_active_i;
			tx_flag_ff <= ~tx_bit_active_i;
		end else if (!rate_ok) begin
			tx_oe_ff <= 1'h0;
			tx_flag_ff <= 1'h1;
		end
	end

	assign gpp_in_o = gpp_in_ff;
	assign dma_req_o = dma_req_ff;
	assign sc_in_o = sc_in_ff;
	assign lb_pin_o = lb_pin_ff;
	assign lb_pin_oe_o = lb_oe_ff;
	assign sc_pin_o = sc_pin_ff;
	assign sc_pin_oe_o = sc_oe_ff;
	assign line_tx_data_o = tx_data_ff;
	assign line_tx_data_oe_o = tx_oe_ff;
	assign line_tx_drive_flag_o = tx_flag_ff;
	assign line_ev_o = line_ev_ff;
	assign rate_bad_o = rate_bad_ff;
endmodule : spm_pin_mux
`default_nettype wire

// ---- core/spm_pkg.sv ----
// shared pin function select: constants, pin positions and carrier types
// assumes one 50 MHz clock; the link clocks are plain sampled inputs
package spm_pkg;

	localparam int SPM_CLK_KHZ = 50000;
	localparam int SPM_GRP_W = 8;
	localparam int SPM_LINE_W = 5;

	// reset values of the two function select bits
	localparam logic SPM_LB_SEL_RST = 1'h0;
	localparam logic SPM_SC_SEL_RST = 1'h0;

	// positions in the local-bus dma pin group (port bits 0..7)
	localparam int SPM_LB_REQ_TX_A = 7;
	localparam int SPM_LB_REQ_RX_A = 6;
	localparam int SPM_LB_REQ_TX_B = 5;
	localparam int SPM_LB_REQ_RX_B = 4;
	localparam int SPM_LB_ACK_TX_A = 3;
	localparam int SPM_LB_ACK_TX_B = 2;
	localparam int SPM_LB_ACK_RX_A = 1;
	localparam int SPM_LB_ACK_RX_B = 0;

	// positions in the serial control pin group (port bits 8..15, index from 8)
	localparam int SPM_SC_SHIFT_CLK = 7;
	localparam int SPM_SC_OUT_MASTER = 6;
	localparam int SPM_SC_IN_MASTER = 5;
	localparam int SPM_SC_RESERVED = 4;
	localparam int SPM_SC_CS0 = 3;

	// positions in the line input group
	localparam int SPM_LN_RX_CLK = 0;
	localparam int SPM_LN_RX_MARK = 1;
	localparam int SPM_LN_RX_DATA = 2;
	localparam int SPM_LN_TX_CLK = 3;
	localparam int SPM_LN_TX_MARK = 4;

	localparam logic [7:0] SPM_GRP_RST = 8'h00;

	typedef enum logic [2:0] {
		SPM_RATE_1544 = 3'b000,
		SPM_RATE_1536 = 3'b001,
		SPM_RATE_2048 = 3'b010,
		SPM_RATE_4096 = 3'b011,
		SPM_RATE_3088 = 3'b100,
		SPM_RATE_6176 = 3'b101,
		SPM_RATE_8192 = 3'b110,
		SPM_RATE_BAD = 3'b111
	} spm_rate_t;

	typedef struct packed {
		logic tx_a;
		logic rx_a;
		logic tx_b;
		logic rx_b;
	} spm_dma_t;

	typedef struct packed {
		logic shift_clk;
		logic shift_clk_oe;
		logic serial_out_master;
		logic serial_out_master_oe;
		logic serial_in_master;
		logic serial_in_master_oe;
		logic [3:0] serial_chip_select;
	} spm_sc_out_t;

	typedef struct packed {
		logic shift_clk;
		logic serial_out_master;
		logic serial_in_master;
	} spm_sc_in_t;

	typedef struct packed {
		logic rx_bit;
		logic rx_frame_first;
		logic rx_data;
		logic tx_bit;
		logic tx_frame_last;
	} spm_line_ev_t;

endpackage : spm_pkg

// ---- core/spm_sync_edge.sv ----
// two-stage synchroniser with rising edge detect for a group of pins
// assumes inputs asynchronous to clk_i; outputs lag the pins by two clocks
`timescale 1ns/1ns
`default_nettype none
module spm_sync_edge #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pins
	input wire logic [WIDTH-1:0] async_i,
	// synchronised view
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] rise_o
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] prev_ff;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign level_o = sync_ff;
	assign rise_o = sync_ff & ~prev_ff;
endmodule : spm_sync_edge
`default_nettype wire

// ---- tb/shared_pin_function_select_tb_top.sv ----
// bench for the shared pin mux: mux tables, pin sync and highway events
// assumes spm_pkg, the checker and the line partner are compiled first
`timescale 1ns/1ns
`default_nettype none
module shared_pin_function_select_tb_top
	import spm_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic lbs = 1'b0, scs = 1'b0, go = 1'b0, tb = 1'b0, ta = 1'b0;
	logic [2:0] md = 3'h0;
	logic [15:0] gout = 16'h0000, goe = 16'h0000, ext = 16'h0000, g_in;
	logic [7:0] lb_o, lb_oe, sc_o, sc_oe, lb_w, sc_w, pat = 8'h00, tp = 8'h00, tact = 8'h00;
	logic rxc, rxm, rxd, txc, txm, txo, txoe, flag, bad, busy;
	spm_dma_t ack = '0, req;
	spm_sc_out_t scd = '0;
	spm_sc_in_t sci;
	spm_line_ev_t ev;
	int mismatches = 0, check_count = 0, rn = 0, tn = 0;
	// pin level: the device where it drives, the outside world elsewhere
	assign lb_w = (lb_oe & lb_o) | (~lb_oe & ext[7:0]);
	assign sc_w = (sc_oe & sc_o) | (~sc_oe & ext[15:8]);
	spm_pin_mux i_spm_pin_mux (.clk_i, .rst_i, .local_bus_dma_select_i(lbs),
		.serial_control_select_i(scs), .line_mode_config_i(md), .gpp_out_i(gout),
		.gpp_oe_i(goe), .gpp_in_o(g_in), .dma_ack_i(ack), .dma_req_o(req), .sc_drive_i(scd),
		.sc_in_o(sci), .lb_pin_i(lb_w), .lb_pin_o(lb_o), .lb_pin_oe_o(lb_oe), .sc_pin_i(sc_w),
		.sc_pin_o(sc_o), .sc_pin_oe_o(sc_oe), .line_rx_clock_i(rxc), .line_rx_frame_marker_i(rxm),
		.line_rx_data_i(rxd), .line_tx_clock_i(txc), .line_tx_frame_marker_i(txm),
		.line_tx_data_o(txo), .line_tx_data_oe_o(txoe), .line_tx_drive_flag_o(flag),
		.tx_bit_i(tb), .tx_bit_active_i(ta), .line_ev_o(ev), .rate_bad_o(bad));
	spm_line_partner i_spm_line_partner (.go_i(go), .pat_i(pat), .rx_clk_o(rxc),
		.rx_mark_o(rxm), .rx_data_o(rxd), .tx_clk_o(txc), .tx_mark_o(txm), .busy_o(busy));
	task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	initial forever #10 clk_i = ~clk_i;
	initial begin
		#200000;
		mismatches++;
		end_sim();
	end
	// highway model: bit index per frame, next transmit bit loaded after each shot
	always @(posedge clk_i) begin
		if (ev.rx_bit) begin
			chk("rx_data", 16'(ev.rx_data), 16'(pat[3'(7 - rn)]));
			chk("rx_first", 16'(ev.rx_frame_first), 16'(rn == 0));
			rn++;
		end
		if (ev.tx_bit) begin
			chk("tx_last", 16'(ev.tx_frame_last), 16'(tn == 7));
			chk("tx_oe", 16'(txoe), 16'(tact[3'(7 - tn)]));
			chk("tx_flag", 16'(flag), 16'(!tact[3'(7 - tn)]));
			if (tact[3'(7 - tn)])
				chk("tx_data", 16'(txo), 16'(tp[3'(7 - tn)]));
			tn++;
		end
		tb <= tp[3'(7 - tn)];
		ta <= tact[3'(7 - tn)];
	end
	initial begin
		logic [7:0] eo, eoe, so, soe;
		logic [3:0] cs;
		logic [31:0] r;
		void'($urandom(32'h284CDA21));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("flag_rst", 16'(flag), 16'h0001);
		for (int i = 0; i < 24; i++) begin
			@(posedge clk_i);
			r = $urandom;
			lbs <= i[0];
			scs <= i[1];
			gout <= 16'($urandom);
			goe <= 16'($urandom);
			scd <= 10'($urandom);
			ext <= r[15:0];
			// each held request is answered on its acknowledge
			ack <= r[7:4];
			cyc(5);
			@(negedge clk_i);
			eoe = lbs ? 8'h0F : goe[7:0];
			eo = lbs ? {4'h0, ack.tx_a, ack.tx_b, ack.rx_a, ack.rx_b} : gout[7:0];
			cs = {<<{scd.serial_chip_select}};
			soe = {scd.shift_clk_oe, scd.serial_out_master_oe, scd.serial_in_master_oe, 5'h0F};
			soe = scs ? soe : goe[15:8];
			so = scs ? {scd.shift_clk, scd.serial_out_master, scd.serial_in_master, 1'b0, cs}
				: gout[15:8];
			chk("lb_o", 16'(lb_o & eoe), 16'(eo & eoe));
			chk("lb_oe", 16'(lb_oe), 16'(eoe));
			chk("sc_o", 16'(sc_o & soe), 16'(so & soe));
			chk("sc_oe", 16'(sc_oe), 16'(soe));
			chk("gpp_in", g_in, {sc_w, lb_w});
			chk("dma_req", 16'(req), 16'(lbs ? lb_w[7:4] : 4'h0));
			chk("sc_in", 16'(sci), 16'(scs ? sc_w[7:5] : 3'h0));
		end
		for (int c = 0; c < 8; c++) begin
			@(posedge clk_i);
			md <= 3'(c);
			pat <= 8'($urandom);
			tp <= 8'($urandom);
			tact <= 8'($urandom);
			rn = 0;
			tn = 0;
			cyc(3);
			go <= 1'b1;
			cyc(2);
			go <= 1'b0;
			for (int k = 0; k < 400 && busy; k++)
				cyc(1);
			cyc(8);
			chk("rx_count", 16'(rn), (c == 7) ? 16'h0000 : 16'h0008);
			chk("tx_count", 16'(tn), (c == 7) ? 16'h0000 : 16'h0008);
			chk("rate_bad", 16'(bad), 16'(c == 7));
		end
		end_sim();
	end
endmodule : shared_pin_function_select_tb_top
`default_nettype wire

// ---- tb/spm_line_partner.sv ----
// far end of the pcm highway: one frame of eight bits per request
// assumes a 160 ns link bit period, unrelated in phase to the block clock
`timescale 1ns/1ns
`default_nettype none
module spm_line_partner (
	// frame request
	input wire logic go_i,
	input wire logic [7:0] pat_i,
	// highway pins
	output logic rx_clk_o,
	output logic rx_mark_o,
	output logic rx_data_o,
	output logic tx_clk_o,
	output logic tx_mark_o,
	output logic busy_o
);
	initial begin
		{rx_clk_o, rx_mark_o, rx_data_o, tx_clk_o, tx_mark_o, busy_o} = 6'h00;
		forever begin
			@(posedge go_i);
			busy_o = 1'b1;
			#13;
			for (int b = 0; b < 8; b++) begin
				// markers and data move while the clock is low, far ahead of its rise
				rx_mark_o = (b == 0);
				tx_mark_o = (b == 7);
				rx_data_o = pat_i[7 - b];
				#80 {rx_clk_o, tx_clk_o} = 2'b11;
				#80 {rx_clk_o, tx_clk_o} = 2'b00;
			end
			// released data shows the inverse; the clocks stand still between frames
			rx_data_o = ~rx_data_o;
			{rx_mark_o, tx_mark_o} = 2'b00;
			#40 busy_o = 1'b0;
		end
	end
endmodule : spm_line_partner
`default_nettype wire

// ---- tb/spm_pin_mux_assertions.sv ----
// checker for the shared pin mux, bound to spm_pin_mux
// assumes one clk_i domain and registered outputs one clock behind their inputs
`timescale 1ns/1ns
`default_nettype none
module spm_pin_mux_assertions
	import spm_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// selects and user side
	input wire logic local_bus_dma_select_i,
	input wire logic serial_control_select_i,
	input wire logic [2:0] line_mode_config_i,
	input wire logic [15:0] gpp_out_i,
	input wire logic [15:0] gpp_oe_i,
	input wire spm_dma_t dma_ack_i,
	input wire spm_sc_out_t sc_drive_i,
	input wire logic tx_bit_i,
	input wire logic tx_bit_active_i,
	// pins and events
	input wire logic [7:0] lb_pin_o,
	input wire logic [7:0] lb_pin_oe_o,
	input wire logic [7:0] sc_pin_o,
	input wire logic [7:0] sc_pin_oe_o,
	input wire logic line_tx_data_o,
	input wire logic line_tx_data_oe_o,
	input wire logic line_tx_drive_flag_o,
	input wire spm_line_ev_t line_ev_o,
	input wire logic rate_bad_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// the first edge after release still shows reset values
	sequence s_live;
		!$past(rst_i);
	endsequence
	sequence s_tx_shot;
		line_ev_o.tx_bit && !rate_bad_o;
	endsequence
	lb_port_a: assert property (s_live ##0 !$past(local_bus_dma_select_i) |->
		lb_pin_o == $past(gpp_out_i[7:0]) && lb_pin_oe_o == $past(gpp_oe_i[7:0]))
		else $error("low port pins do not follow the port");
	lb_dma_a: assert property (s_live ##0 $past(local_bus_dma_select_i) |->
		lb_pin_oe_o == 8'h0F && lb_pin_o[3:0] == {$past(dma_ack_i.tx_a),
		$past(dma_ack_i.tx_b), $past(dma_ack_i.rx_a), $past(dma_ack_i.rx_b)})
		else $error("dma pins wrong");
	sc_port_a: assert property (s_live ##0 !$past(serial_control_select_i) |->
		sc_pin_o == $past(gpp_out_i[15:8]) && sc_pin_oe_o == $past(gpp_oe_i[15:8]))
		else $error("high port pins do not follow the port");
	sc_ser_a: assert property (s_live ##0 $past(serial_control_select_i) |->
		sc_pin_oe_o[4:0] == 5'h0F && sc_pin_oe_o[7] == $past(sc_drive_i.shift_clk_oe)
		&& sc_pin_o[3] == $past(sc_drive_i.serial_chip_select[0]))
		else $error("serial control pins wrong");
	drive_flag_a: assert property (line_tx_drive_flag_o != line_tx_data_oe_o)
		else $error("drive flag disagrees with data enable");
	rx_first_a: assert property (line_ev_o.rx_frame_first |-> line_ev_o.rx_bit)
		else $error("frame start without a receive bit");
	tx_last_a: assert property (line_ev_o.tx_frame_last |-> line_ev_o.tx_bit)
		else $error("frame end without a transmit bit");
	tx_drive_a: assert property (s_tx_shot |->
		line_tx_data_oe_o == $past(tx_bit_active_i)
		&& (!line_tx_data_oe_o || line_tx_data_o == $past(tx_bit_i)))
		else $error("transmit data drive wrong");
	rate_flag_a: assert property (s_live |-> rate_bad_o == ($past(line_mode_config_i) == 3'h7))
		else $error("rate flag wrong");
	rate_quiet_a: assert property (rate_bad_o [*3] |->
		!line_ev_o.rx_bit && !line_ev_o.tx_bit && !line_tx_data_oe_o)
		else $error("line active under illegal rate");
endmodule : spm_pin_mux_assertions
bind spm_pin_mux spm_pin_mux_assertions i_spm_pin_mux_assertions (.clk_i, .rst_i,
	.local_bus_dma_select_i, .serial_control_select_i, .line_mode_config_i, .gpp_out_i,
	.gpp_oe_i, .dma_ack_i, .sc_drive_i, .tx_bit_i, .tx_bit_active_i, .lb_pin_o, .lb_pin_oe_o,
	.sc_pin_o, .sc_pin_oe_o, .line_tx_data_o, .line_tx_data_oe_o, .line_tx_drive_flag_o,
	.line_ev_o, .rate_bad_o);
`default_nettype wire
